// file: rtl/dsm_dir_decoder.sv
/*
  Direction of rotation from two phase-shifted tracks.
  Assumes both tracks are synchronous to hclk; a leading means forward.
*/
`timescale 1ns/100ps
module dsm_dir_decoder (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic trk_a,
  input wire logic trk_b,
  output logic dir_fwd
);
  logic a_d;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_d <= 1'b0;
      dir_fwd <= 1'b1;
    end else begin
      a_d <= trk_a;
      if (trk_a && !a_d) begin
        dir_fwd <= ~trk_b;
      end else if (!trk_a && a_d) begin
        dir_fwd <= trk_b;
      end
    end
  end
endmodule

// file: rtl/dsm_freq_meter.sv
/*
  Edge-count frequency meter for one input channel.
  Assumes sig is synchronous to hclk and gate_tick is a one-cycle pulse.
*/
`timescale 1ns/100ps
module dsm_freq_meter
  import dsm_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic sig,
  input wire logic gate_tick,
  output logic [CNT_W-1:0] freq_cnt
);
  logic sig_d;
  logic [CNT_W-1:0] run;
  wire rise = sig & ~sig_d;
  // Saturate so a very fast input never wraps to look like standstill
  wire sat = &run;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sig_d <= 1'b0;
      run <= '0;
      freq_cnt <= '0;
    end else begin
      sig_d <= sig;
      if (gate_tick) begin
        freq_cnt <= run;
        run <= {{(CNT_W-1){1'b0}}, rise};
      end else if (rise && !sat) begin
        run <= run + 16'h0001;
      end
    end
  end
endmodule

// file: rtl/dsm_pkg.sv
/*
  Constants shared by the dual-axis speed monitor: timing, register map,
  field positions, reset values and sensor mode codes.
  Assumes a 40 MHz hclk.
*/
package dsm_pkg;
  localparam int CLK_HZ = 40_000_000;
  // Frequency gate: edges are counted over this window
  localparam int GATE_MS = 500;
  localparam int GATE_CYCLES = CLK_HZ / 1000 * GATE_MS;
  localparam int MIN_FREQ_HZ = 2;
  localparam int CNT_W = 16;
  // 2 Hz expressed as rising edges per gate window
  localparam logic [15:0] MIN_CNT = 16'(MIN_FREQ_HZ * GATE_MS / 1000);
  localparam logic [15:0] MISMATCH_TOL = 16'h0001;
  // A wire must look broken this long before it counts as open
  localparam int OPEN_NS = 1000;
  localparam int OPEN_CYCLES = (OPEN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [7:0] OPEN_MAX = 8'(OPEN_CYCLES);
  localparam int NUM_AXES = 2;
  localparam int NUM_SPD = 8;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CFG1 = 8'h04;
  localparam logic [7:0] OFS_CFG2 = 8'h08;
  localparam logic [7:0] OFS_STILL1 = 8'h0c;
  localparam logic [7:0] OFS_STILL2 = 8'h10;
  localparam logic [7:0] OFS_SPD1 = 8'h20;
  localparam logic [7:0] OFS_SPD2 = 8'h40;
  localparam logic [7:0] OFS_STATUS = 8'h60;
  localparam logic [7:0] OFS_SPEED1 = 8'h64;
  localparam logic [7:0] OFS_SPEED2 = 8'h68;

  localparam int CTRL_LEGACY = 0;
  localparam int CTRL_STOP_CLR = 1;
  localparam int CFG_SHEAR_EN = 2;
  localparam int CFG_SEL_LSB = 4;

  localparam logic [1:0] MODE_ENC = 2'h0;
  localparam logic [1:0] MODE_PROX = 2'h1;
  localparam logic [1:0] MODE_ENC_PROX = 2'h2;
  localparam logic [1:0] MODE_ENC_PAIR = 2'h3;

  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [15:0] STILL_RST = 16'h0001;
  localparam logic [15:0] SPD_RST = 16'hffff;
endpackage

// file: rtl/dsm_speed_monitor.sv
/*
  Dual-axis safety speed monitor with an AHB-Lite register slave.
  Assumes all sensor inputs are already synchronous to hclk and that the
  base unit reads the per-axis outputs as safety signals.
*/
// Behaviour
// - Standstill, speed and direction evaluated per axis, all reported outward.
// - Track or proximity frequency mismatch above standstill and 2 Hz makes axis safe.
// - New behaviour: direction disagreement makes only that axis safe, self-clearing.
// - Legacy behaviour: direction disagreement stops the whole system.
// - Open circuit or dead sensor on one channel makes that axis safe; proximity is unchecked in encoder plus proximity mode.
// - Overspeed output is 0 when safe; base unit must shut down on 0.
// - Encoder plus proximity mode watches track A, track B and proximity.
// - In that mode standstill needs two of three signals below standstill.
// - Shearpin break: both tracks still while proximity input still moves.
// - Shearpin break makes axis safe and clears itself when signals change.
// - Eight configurable speed thresholds per axis compared with measured speed.
`timescale 1ns/100ps
module dsm_speed_monitor
  import dsm_pkg::*;
#(
  parameter int unsigned GATE_CYC = GATE_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic axis1_enc_a,
  input wire logic axis1_enc_a_n,
  input wire logic axis1_enc_b,
  input wire logic axis1_enc_b_n,
  input wire logic axis2_enc_a,
  input wire logic axis2_enc_a_n,
  input wire logic axis2_enc_b,
  input wire logic axis2_enc_b_n,
  input wire logic axis1_prox_in_a,
  input wire logic axis1_prox_in_b,
  input wire logic axis2_prox_in_a,
  input wire logic axis2_prox_in_b,
  output logic [1:0] axis_standstill,
  output logic [1:0] axis_speed_ok,
  output logic [1:0] axis_dir_fwd,
  output logic [1:0] axis_fault,
  output logic [1:0] shearpin_fault_status,
  output logic system_stop
);
  logic [7:0] cfg [NUM_AXES];
  logic [15:0] still_thr [NUM_AXES];
  logic [15:0] spd_thr [NUM_AXES][NUM_SPD];
  logic legacy;
  logic [7:0] stat [NUM_AXES];
  logic [31:0] gate_cnt;
  logic gate_tick;
  logic wr_pend;
  logic [7:0] wr_addr;

  wire [1:0] enc_a = {axis2_enc_a, axis1_enc_a};
  wire [1:0] enc_a_n = {axis2_enc_a_n, axis1_enc_a_n};
  wire [1:0] enc_b = {axis2_enc_b, axis1_enc_b};
  wire [1:0] enc_b_n = {axis2_enc_b_n, axis1_enc_b_n};
  wire [1:0] prox_a = {axis2_prox_in_a, axis1_prox_in_a};
  wire [1:0] prox_b = {axis2_prox_in_b, axis1_prox_in_b};

  logic [1:0] next_still;
  logic [1:0] next_spd_ok;
  logic [1:0] next_dir;
  logic [1:0] next_fault;
  logic [1:0] next_shear;
  logic [1:0] dir_fault;
  logic [7:0] next_stat [NUM_AXES];
  logic [15:0] speed [NUM_AXES];

  function automatic logic mismatch(input logic [15:0] x, input logic [15:0] y,
                                    input logic [15:0] thr);
    logic [15:0] hi;
    logic [15:0] lo;
    hi = (x > y) ? x : y;
    lo = (x > y) ? y : x;
    mismatch = ((hi - lo) > MISMATCH_TOL) && (hi > thr) && (hi > MIN_CNT);
  endfunction

  // Gate timer shared by all meters so channels compare like with like
  wire gate_last = (gate_cnt == 32'(GATE_CYC - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate_cnt <= '0;
      gate_tick <= 1'b0;
    end else begin
      gate_tick <= gate_last;
      gate_cnt <= gate_last ? 32'h0 : gate_cnt + 32'h1;
    end
  end

  for (genvar ax = 0; ax < NUM_AXES; ax++) begin : g_axis
    logic [CNT_W-1:0] c_ea;
    logic [CNT_W-1:0] c_eb;
    logic [CNT_W-1:0] c_pa;
    logic [CNT_W-1:0] c_pb;
    logic dir_e;
    logic dir_p;
    logic [7:0] open_cnt;
    logic [NUM_SPD-1:0] spd_over;

    dsm_freq_meter u_ea (.hclk(hclk), .hresetn(hresetn), .sig(enc_a[ax]),
                         .gate_tick(gate_tick), .freq_cnt(c_ea));
    dsm_freq_meter u_eb (.hclk(hclk), .hresetn(hresetn), .sig(enc_b[ax]),
                         .gate_tick(gate_tick), .freq_cnt(c_eb));
    dsm_freq_meter u_pa (.hclk(hclk), .hresetn(hresetn), .sig(prox_a[ax]),
                         .gate_tick(gate_tick), .freq_cnt(c_pa));
    dsm_freq_meter u_pb (.hclk(hclk), .hresetn(hresetn), .sig(prox_b[ax]),
                         .gate_tick(gate_tick), .freq_cnt(c_pb));
    dsm_dir_decoder u_de (.hclk(hclk), .hresetn(hresetn), .trk_a(enc_a[ax]),
                          .trk_b(enc_b[ax]), .dir_fwd(dir_e));
    dsm_dir_decoder u_dp (.hclk(hclk), .hresetn(hresetn), .trk_a(prox_a[ax]),
                          .trk_b(prox_b[ax]), .dir_fwd(dir_p));

    wire [1:0] mode = cfg[ax][1:0];
    wire use_enc = (mode != MODE_PROX);
    wire use_pair = (mode == MODE_PROX) || (mode == MODE_ENC_PAIR);
    wire [15:0] thr = still_thr[ax];
    wire s_ea = (c_ea <= thr);
    wire s_eb = (c_eb <= thr);
    wire s_pa = (c_pa <= thr);
    wire s_pb = (c_pb <= thr);
    wire still_3 = (s_ea & s_eb) | (s_ea & s_pa) | (s_eb & s_pa);
    wire still_enc = s_ea & s_eb;
    wire still_prox = s_pa & s_pb;
    wire still = (mode == MODE_ENC) ? still_enc :
                 (mode == MODE_PROX) ? still_prox :
                 (mode == MODE_ENC_PROX) ? still_3 :
                 (still_enc & still_prox);
    wire mm = (use_enc & mismatch(c_ea, c_eb, thr)) |
              (use_pair & mismatch(c_pa, c_pb, thr));
    // Direction can only be cross-checked when a second pair exists
    assign dir_fault[ax] = (mode == MODE_ENC_PAIR) & ~s_ea & ~s_pa &
                           (dir_e != dir_p);
    wire shear = cfg[ax][CFG_SHEAR_EN] & (mode == MODE_ENC_PROX) &
                 s_ea & s_eb & ~s_pa;
    // Differential pair equal or both proximity switches low means a dead wire
    wire open_cond = (use_enc & ((enc_a[ax] == enc_a_n[ax]) |
                                 (enc_b[ax] == enc_b_n[ax]))) |
                     (use_pair & ~prox_a[ax] & ~prox_b[ax]);
    wire open_flt = (open_cnt == OPEN_MAX);
    wire fault = mm | open_flt | shear | system_stop |
                 (dir_fault[ax] & ~legacy);
    wire [2:0] sel = cfg[ax][CFG_SEL_LSB +: 3];

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        open_cnt <= '0;
      end else if (!open_cond) begin
        open_cnt <= '0;
      end else if (!open_flt) begin
        open_cnt <= open_cnt + 8'h01;
      end
    end

    for (genvar i = 0; i < NUM_SPD; i++) begin : g_spd
      assign spd_over[i] = (speed[ax] > spd_thr[ax][i]);
    end

    assign speed[ax] = use_enc ? c_ea : c_pa;
    assign next_still[ax] = still & ~fault;
    assign next_spd_ok[ax] = ~spd_over[sel] & ~fault;
    assign next_dir[ax] = use_enc ? dir_e : dir_p;
    assign next_fault[ax] = fault;
    assign next_shear[ax] = shear;
    assign next_stat[ax] = {fault, shear, open_flt, dir_fault[ax], mm,
                            ~next_spd_ok[ax], next_dir[ax], next_still[ax]};
  end

  // A legacy-mode direction conflict latches a stop that software clears;
  // a new conflict in the clearing cycle keeps it set
  wire stop_set = legacy & (|dir_fault);
  wire stop_clr = wr_pend && (wr_addr == OFS_CTRL) && hwdata[CTRL_STOP_CLR];

  // Status copies are registered with the pins, so a read matches them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      axis_standstill <= 2'h0;
      axis_speed_ok <= 2'h0;
      axis_dir_fwd <= 2'h0;
      axis_fault <= 2'h3;
      shearpin_fault_status <= 2'h0;
      stat <= '{default: 8'h00};
    end else begin
      axis_standstill <= next_still;
      axis_speed_ok <= next_spd_ok;
      axis_dir_fwd <= next_dir;
      axis_fault <= next_fault;
      shearpin_fault_status <= next_shear;
      stat <= next_stat;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      system_stop <= 1'b0;
    end else if (stop_set) begin
      system_stop <= 1'b1;
    end else if (stop_clr) begin
      system_stop <= 1'b0;
    end
  end

  // AHB-Lite slave: zero wait states, reads answered in the data phase
  wire accept = hsel && htrans[1] && hready;
  wire [7:0] a = haddr[7:0];
  wire in_map = (haddr[31:8] == 24'h0);
  wire spd_hit = (a[7:5] == OFS_SPD1[7:5]) || (a[7:5] == OFS_SPD2[7:5]);
  wire [31:0] rd_spd = {16'h0, spd_thr[a[6]][a[4:2]]};
  // One named hit per register keeps the read and write maps side by side
  wire r_ctrl = (a == OFS_CTRL);
  wire r_cfg1 = (a == OFS_CFG1);
  wire r_cfg2 = (a == OFS_CFG2);
  wire r_still1 = (a == OFS_STILL1);
  wire r_still2 = (a == OFS_STILL2);
  wire r_status = (a == OFS_STATUS);
  wire r_speed1 = (a == OFS_SPEED1);
  wire r_speed2 = (a == OFS_SPEED2);
  wire [31:0] rd_val = !in_map ? 32'h0 :
    r_ctrl ? {31'h0, legacy} :
    r_cfg1 ? {24'h0, cfg[0]} :
    r_cfg2 ? {24'h0, cfg[1]} :
    r_still1 ? {16'h0, still_thr[0]} :
    r_still2 ? {16'h0, still_thr[1]} :
    spd_hit ? rd_spd :
    r_status ? {15'h0, system_stop, stat[1], stat[0]} :
    r_speed1 ? {16'h0, speed[0]} :
    r_speed2 ? {16'h0, speed[1]} : 32'h0;
  // Writes decode the address held over from the address phase
  wire w_ctrl = wr_pend && (wr_addr == OFS_CTRL);
  wire w_cfg1 = wr_pend && (wr_addr == OFS_CFG1);
  wire w_cfg2 = wr_pend && (wr_addr == OFS_CFG2);
  wire w_still1 = wr_pend && (wr_addr == OFS_STILL1);
  wire w_still2 = wr_pend && (wr_addr == OFS_STILL2);
  wire w_spd = wr_pend && ((wr_addr[7:5] == OFS_SPD1[7:5]) ||
                           (wr_addr[7:5] == OFS_SPD2[7:5]));

  // No wait states, so the response flops only ever hold ready and OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= accept && hwrite && in_map;
      wr_addr <= a;
    end
  end

  // Read data is loaded at the address phase and stands until the next read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (accept && !hwrite) begin
      hrdata <= rd_val;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      legacy <= 1'b0;
    end else if (w_ctrl) begin
      legacy <= hwdata[CTRL_LEGACY];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg <= '{default: CFG_RST};
    end else begin
      if (w_cfg1) cfg[0] <= hwdata[7:0];
      if (w_cfg2) cfg[1] <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      still_thr <= '{default: STILL_RST};
      spd_thr <= '{default: '{default: SPD_RST}};
    end else begin
      if (w_still1) still_thr[0] <= hwdata[15:0];
      if (w_still2) still_thr[1] <= hwdata[15:0];
      if (w_spd) spd_thr[wr_addr[6]][wr_addr[4:2]] <= hwdata[15:0];
    end
  end
endmodule

// file: test/dsm_base_unit.sv
/* Base unit model: turns the monitor's outputs into a shutdown request.
   Assumes the outputs are read as plain levels, no bus latency. */
`timescale 1ns/100ps
module dsm_base_unit (
  input wire logic [1:0] axis_speed_ok,
  input wire logic system_stop,
  output logic shutdown
);
  // A low overspeed output is never read as a pass, in any mode
  assign shutdown = system_stop || (axis_speed_ok != 2'b11);
endmodule

// file: test/dsm_speed_monitor_assertions.sv
/* Port assertions for the speed monitor.
   Assumes one hclk domain; bound to every instance. */
`timescale 1ns/100ps
module dsm_sva_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [1:0] axis_standstill,
  input wire logic [1:0] axis_speed_ok,
  input wire logic [1:0] axis_fault,
  input wire logic [1:0] shearpin_fault_status,
  input wire logic system_stop
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd_taken;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence rd_status;
    rd_taken ##0 haddr == 32'h60;
  endsequence
  chk_bus_ready: assert property (hreadyout) else $error("hreadyout low");
  chk_bus_okay: assert property (!hresp) else $error("hresp not okay");
  chk_fault_overspeed: assert property ((axis_fault & axis_speed_ok) == 2'b00)
    else $error("faulted axis shows speed ok");
  chk_fault_still: assert property ((axis_fault & axis_standstill) == 2'b00)
    else $error("faulted axis shows standstill");
  chk_shear_safe: assert property ((shearpin_fault_status & ~axis_fault) == 2'b00)
    else $error("shearpin break without safe axis");
  chk_rdata_hold: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
    else $error("hrdata moved without a read");
  chk_unmapped_zero: assert property
    ((rd_taken ##0 (haddr[31:8] != 0 || haddr[7:0] > 8'h68)) |=> hrdata == 0)
    else $error("unmapped read not zero");
  chk_status_fault: assert property (rd_status |=>
    hrdata[7] == $past(axis_fault[0]) && hrdata[15] == $past(axis_fault[1]))
    else $error("status fault bits differ");
  chk_status_stop: assert property (rd_status |=> hrdata[16] == $past(system_stop))
    else $error("status stop bit differs");
endmodule
bind dsm_speed_monitor dsm_sva_chk u_dsm_sva_chk (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata, .axis_standstill,
  .axis_speed_ok, .axis_fault, .shearpin_fault_status, .system_stop);

// file: test/tb_dsm_speed_monitor.sv
/* Self-checking bench: AHB-Lite register calls and sensor waveforms.
   Assumes a 1000-cycle gate, so a 40-cycle track period gives 25 edges. */
`timescale 1ns/100ps
module tb_dsm_speed_monitor;
  import dsm_pkg::*;
  localparam int G = 1000;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, stop, shutdown;
  logic [1:0] htrans = 0, still, sok, fwd, flt, shr;
  logic [1:0] ea = 0, eb = 0, pa = 0, pb = 0, brk = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic [3:0] mv [2] = '{default: 0};
  logic [1:0] rv [2] = '{default: 0};
  logic [5:0] ph = 0;
  int errors = 0, samples_checked = 0;

  dsm_speed_monitor #(.GATE_CYC(G)) u_dsm_speed_monitor (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .axis1_enc_a(ea[0]), .axis1_enc_a_n(ea[0] ^ ~brk[0]), .axis1_enc_b(eb[0]),
    .axis1_enc_b_n(~eb[0]), .axis2_enc_a(ea[1]), .axis2_enc_a_n(ea[1] ^ ~brk[1]),
    .axis2_enc_b(eb[1]), .axis2_enc_b_n(~eb[1]), .axis1_prox_in_a(pa[0]),
    .axis1_prox_in_b(pb[0]), .axis2_prox_in_a(pa[1]), .axis2_prox_in_b(pb[1]),
    .axis_standstill(still), .axis_speed_ok(sok), .axis_dir_fwd(fwd), .axis_fault(flt),
    .shearpin_fault_status(shr), .system_stop(stop));
  dsm_base_unit u_dsm_base_unit (.axis_speed_ok(sok), .system_stop(stop), .shutdown);

  initial forever #12.5 hclk = ~hclk;
  // Second track lags by a quarter period, or leads when reversed
  function automatic logic trk(logic [5:0] p, logic r);
    return ((int'(p) + (r ? 10 : 30)) % 40) < 20;
  endfunction
  always @(posedge hclk) begin
    ph <= (ph == 6'd39) ? 6'd0 : ph + 6'd1;
    for (int i = 0; i < 2; i++) begin
      ea[i] <= mv[i][0] && ph < 20;
      eb[i] <= mv[i][1] && trk(ph, rv[i][0]);
      pa[i] <= mv[i][2] && ph < 20;
      pb[i] <= mv[i][3] && trk(ph, rv[i][1]);
    end
  end
  task automatic wrap_up;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge hclk);
    errors++;
    wrap_up();
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(0, a, 0);
    chk($sformatf("reg %h", a), e, q);
  endtask
  // Counts lag up to two gates, so allow a few whole windows
  task automatic gates(input int n);
    repeat (n * G + 5) @(posedge hclk);
  endtask
  initial begin
    repeat (3) @(posedge hclk);
    chk("fault in reset", 3, flt);
    chk("speed_ok in reset", 0, sok);
    repeat (2) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    rd(OFS_CFG1, 0);
    rd(OFS_STILL1, 1);
    rd(OFS_SPD1 + 8'h1c, 32'hffff);
    rd(OFS_SPD2, 32'hffff);
    rd(8'h7c, 0);
    gates(3);
    chk("standstill", 3, still);
    chk("fault idle", 0, flt);
    chk("shutdown idle", 0, shutdown);
    mv[0] <= 4'h3;
    gates(3);
    chk("standstill moving", 2, still);
    chk("dir fwd", 1, fwd[0]);
    rd(OFS_SPEED1, 25);
    bus(1, OFS_SPD1, 10);
    gates(1);
    chk("overspeed", 2, sok);
    chk("shutdown", 1, shutdown);
    bus(1, OFS_CFG1, 32'h10);
    repeat (5) @(posedge hclk);
    chk("speed index 1", 3, sok);
    rv[0] <= 2'b01;
    gates(3);
    chk("dir rev", 0, fwd[0]);
    rv[0] <= 0;
    mv[0] <= 4'h4;
    bus(1, OFS_CFG1, 32'h12);
    gates(3);
    chk("two of three still", 1, still[0]);
    chk("no shear when off", 0, flt[0]);
    bus(1, OFS_CFG1, 32'h16);
    repeat (5) @(posedge hclk);
    chk("shear", 1, shr);
    chk("shear safe", 1, flt[0]);
    mv[0] <= 0;
    gates(3);
    chk("shear gone", 0, shr);
    chk("shear fault gone", 0, flt[0]);
    bus(1, OFS_CTRL, 1);
    bus(1, OFS_CFG1, 32'h13);
    mv[0] <= 4'hf;
    rv[0] <= 2'b10;
    gates(3);
    chk("legacy stop", 1, stop);
    bus(0, OFS_STATUS, 0);
    chk("status stop", 1, q[16]);
    rv[0] <= 0;
    gates(3);
    bus(1, OFS_CTRL, 2);
    repeat (5) @(posedge hclk);
    chk("stop cleared", 0, stop);
    rv[0] <= 2'b10;
    gates(3);
    chk("dir conflict", 1, flt[0]);
    chk("no stop", 0, stop);
    rv[0] <= 0;
    gates(3);
    chk("conflict gone", 0, flt[0]);
    bus(1, OFS_CFG1, 32'h10);
    mv[0] <= 4'h1;
    gates(3);
    chk("mismatch", 1, flt[0]);
    mv[1] <= 4'hc;
    bus(1, OFS_CFG2, 32'h01);
    gates(3);
    chk("prox moving", 0, still[1]);
    chk("prox dir fwd", 1, fwd[1]);
    chk("prox pair ok", 0, flt[1]);
    rd(OFS_SPEED2, 25);
    rv[1] <= 2'b10;
    gates(3);
    chk("prox dir rev", 0, fwd[1]);
    mv[1] <= 4'h4;
    gates(3);
    chk("prox mismatch", 1, flt[1]);
    bus(1, OFS_CFG2, 0);
    mv[1] <= 0;
    rv[1] <= 0;
    repeat (5) @(posedge hclk);
    chk("prox released", 0, flt[1]);
    brk[1] <= 1;
    repeat (30) @(posedge hclk);
    chk("open early", 0, flt[1]);
    repeat (30) @(posedge hclk);
    chk("open", 1, flt[1]);
    wrap_up();
  end
endmodule
